/* core/isw_ctrl.sv */
// Purpose: Interrupt collection, power-down entry and wake-up, and watchdog of a small 8-bit controller.
// Assumes: clk keeps running while the core oscillator is gated off; pins arrive asynchronously.
// Notes: APB answers with one wait state; every output is a flip-flop of the state record.
`timescale 1ns/1ps

module isw_ctrl #(
  parameter int WDT_CYCLES = isw_pkg::WDT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire isw_pkg::isw_apb_req_t apb_req,
  output isw_pkg::isw_apb_rsp_t apb_rsp,
  input wire isw_pkg::isw_core_evt_t core_evt,
  output isw_pkg::isw_core_ctl_t core_ctl,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_pins,
  input wire logic [7:0] configuration_word
);

  typedef struct packed {
    isw_pkg::isw_phase_t phase;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [3:0] port_s1;
    logic [3:0] port_s2;
    logic [3:0] port_latch;
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_interrupt_flags;
    logic [7:0] option_control;
    logic [7:0] peripheral_interrupt_enables;
    logic [7:0] cfg;
    logic cfg_loaded;
    logic timeout_status;
    logic powerdown_status;
    logic [1:0] take_cnt;
    logic [6:0] pre;
    logic [21:0] wdt;
    isw_pkg::isw_apb_rsp_t rsp;
    isw_pkg::isw_core_ctl_t ctl;
  } isw_state_t;

  isw_state_t s;
  isw_state_t next_s;
  logic ext_edge;
  logic port_chg;
  logic any_enabled;
  logic wdt_timeout;
  logic wr_fire;

  assign apb_rsp = s.rsp;
  assign core_ctl = s.ctl;

  // Event detection and source gating, shared by the update logic and the checks
  always_comb begin
    logic [6:0] mask;
    logic step;
    mask = 7'h00;
    step = 1'b0;
    // Edge polarity follows the option bit; the third stage only holds the old level
    ext_edge = s.option_control[isw_pkg::B_EDGE] ? (s.ext_s2 & ~s.ext_s3) : (~s.ext_s2 & s.ext_s3);
    // A read landing on the second phase refreshes the latch and may hide the change
    port_chg = (s.port_s2 != s.port_latch) && !(core_evt.port_read && s.phase == isw_pkg::Q2);
    any_enabled = (s.interrupt_control[isw_pkg::B_TIMER_OVERFLOW_ENABLE] & s.interrupt_control[isw_pkg::B_TIMER_OVERFLOW_FLAG])
      | (s.interrupt_control[isw_pkg::B_EXTIE] & s.interrupt_control[isw_pkg::B_EXTIF])
      | (s.interrupt_control[isw_pkg::B_PCIE] & s.interrupt_control[isw_pkg::B_PCIF])
      | (s.interrupt_control[isw_pkg::B_PERIPHERAL_IRQ_ENABLE] & s.peripheral_interrupt_enables[isw_pkg::B_CMP]
         & s.peripheral_interrupt_flags[isw_pkg::B_CMP]);
    // Prescaler mask gives 1:1 up to 1:128 when assigned to the watchdog
    mask = 7'((8'h01 << s.option_control[isw_pkg::B_PS +: 3]) - 8'h01);
    step = !s.option_control[isw_pkg::B_PSA] || ((s.pre & mask) == mask);
    wdt_timeout = s.cfg_loaded && s.cfg[isw_pkg::B_WATCHDOG_ENABLE_CFG] && step
      && (s.wdt == 22'(WDT_CYCLES - 1));
    wr_fire = apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite;
  end

  // Whole next state; pulses default low every cycle
  always_comb begin
    logic [7:0] rd;
    logic hit;
    logic ro;
    logic [7:0] wd;
    rd = 8'h00;
    hit = 1'b0;
    ro = 1'b0;
    wd = apb_req.pwdata[7:0];
    next_s = s;
    next_s.phase = isw_pkg::isw_phase_t'(s.phase + 2'h1);
    next_s.ext_s1 = ext_irq_pin;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_s3 = s.ext_s2;
    next_s.port_s1 = port_b_pins;
    next_s.port_s2 = s.port_s1;
    next_s.ctl.phase = next_s.phase;
    next_s.ctl.vector_addr = isw_pkg::IRQ_VECTOR;
    next_s.ctl.irq_vector_take = 1'b0;
    next_s.ctl.nop_cycle = 1'b0;
    next_s.ctl.watchdog_reset = 1'b0;
    next_s.ctl.wake_pulse = 1'b0;
    next_s.rsp.pready = 1'b0;
    next_s.rsp.pslverr = 1'b0;

    // Strap is caught on the first clock after reset release
    if (!s.cfg_loaded) begin
      next_s.cfg = configuration_word;
      next_s.cfg_loaded = 1'b1;
    end

    // Address decode, shared by read and write
    if (apb_req.paddr == isw_pkg::ADDR_INT_CTL) begin
      hit = 1'b1;
      rd = s.interrupt_control;
    end else if (apb_req.paddr == isw_pkg::ADDR_PER_FLAGS) begin
      hit = 1'b1;
      rd = s.peripheral_interrupt_flags;
    end else if (apb_req.paddr == isw_pkg::ADDR_OPTION) begin
      hit = 1'b1;
      rd = s.option_control;
    end else if (apb_req.paddr == isw_pkg::ADDR_PER_ENABLES) begin
      hit = 1'b1;
      rd = s.peripheral_interrupt_enables;
    end else if (apb_req.paddr == isw_pkg::ADDR_CORE_STATUS) begin
      hit = 1'b1;
      ro = 1'b1;
      rd = 8'h00;
      rd[isw_pkg::B_TO] = s.timeout_status;
      rd[isw_pkg::B_PD] = s.powerdown_status;
    end else if (apb_req.paddr == isw_pkg::ADDR_CONFIG) begin
      hit = 1'b1;
      ro = 1'b1;
      rd = s.cfg;
    end

    // First access cycle loads the answer; the second completes it
    if (apb_req.psel && apb_req.penable && !s.rsp.pready) begin
      next_s.rsp.pready = 1'b1;
      next_s.rsp.prdata = {24'h00_0000, hit ? rd : 8'h00};
      next_s.rsp.pslverr = !hit || (ro && apb_req.pwrite);
    end

    // Writes land only at the completing edge; unused bits of the flag word stay zero
    if (wr_fire && hit && !ro) begin
      if (apb_req.paddr == isw_pkg::ADDR_INT_CTL) begin
        next_s.interrupt_control = wd;
      end else if (apb_req.paddr == isw_pkg::ADDR_PER_FLAGS) begin
        next_s.peripheral_interrupt_flags = 8'h00;
        next_s.peripheral_interrupt_flags[isw_pkg::B_CMP] = wd[isw_pkg::B_CMP];
      end else if (apb_req.paddr == isw_pkg::ADDR_OPTION) begin
        next_s.option_control = wd;
      end else if (apb_req.paddr == isw_pkg::ADDR_PER_ENABLES) begin
        next_s.peripheral_interrupt_enables = 8'h00;
        next_s.peripheral_interrupt_enables[isw_pkg::B_CMP] = wd[isw_pkg::B_CMP];
      end
    end

    // Flag sets come after the write so an event in a clearing cycle survives
    if (core_evt.port_read) begin
      next_s.port_latch = s.port_s2;
    end
    if (ext_edge) begin
      next_s.interrupt_control[isw_pkg::B_EXTIF] = 1'b1;
    end
    if (core_evt.timer_overflow) begin
      next_s.interrupt_control[isw_pkg::B_TIMER_OVERFLOW_FLAG] = 1'b1;
    end
    if (port_chg) begin
      next_s.interrupt_control[isw_pkg::B_PCIF] = 1'b1;
    end
    if (core_evt.comparator_event) begin
      next_s.peripheral_interrupt_flags[isw_pkg::B_CMP] = 1'b1;
    end

    // Recognition in the first phase, vector after two more instruction cycles
    if (s.phase == isw_pkg::Q1) begin
      if (s.take_cnt != 2'h0) begin
        next_s.take_cnt = s.take_cnt - 2'h1;
        if (s.take_cnt == 2'h1) begin
          next_s.ctl.irq_vector_take = 1'b1;
          next_s.interrupt_control[isw_pkg::B_GIE] = 1'b0;
        end
      end else if (s.interrupt_control[isw_pkg::B_GIE] && any_enabled && !s.ctl.sleeping) begin
        next_s.take_cnt = isw_pkg::TAKE_LATENCY;
      end
    end

    // Return from service re-enables; clearing the enable drops a take in flight
    if (core_evt.return_from_irq) begin
      next_s.interrupt_control[isw_pkg::B_GIE] = 1'b1;
    end
    if (core_evt.gie_clear_instr) begin
      next_s.interrupt_control[isw_pkg::B_GIE] = 1'b0;
      next_s.take_cnt = 2'h0;
      next_s.ctl.nop_cycle = (s.take_cnt != 2'h0) || any_enabled;
      next_s.ctl.irq_vector_take = 1'b0;
    end

    // Watchdog count on the always-running clock
    next_s.pre = s.pre + 7'h01;
    if (s.cfg_loaded && s.cfg[isw_pkg::B_WATCHDOG_ENABLE_CFG] && (!s.option_control[isw_pkg::B_PSA]
        || ((s.pre & 7'((8'h01 << s.option_control[isw_pkg::B_PS +: 3]) - 8'h01))
        == 7'((8'h01 << s.option_control[isw_pkg::B_PS +: 3]) - 8'h01)))) begin
      next_s.wdt = s.wdt + 22'h00_0001;
    end
    if (wdt_timeout) begin
      next_s.wdt = 22'h00_0000;
      next_s.timeout_status = 1'b0;
      next_s.ctl.watchdog_reset = !s.ctl.sleeping;
    end

    // Sleep entry
    if (core_evt.sleep_instr) begin
      next_s.ctl.sleeping = 1'b1;
      next_s.ctl.osc_enable = 1'b0;
      next_s.powerdown_status = 1'b0;
      next_s.timeout_status = !wdt_timeout;
    end

    // Wake-up ignores the global enable; vectoring then follows the normal path
    if (s.ctl.sleeping && (any_enabled || wdt_timeout)) begin
      next_s.ctl.sleeping = 1'b0;
      next_s.ctl.osc_enable = 1'b1;
      next_s.ctl.wake_pulse = 1'b1;
    end

    // Clear, sleep and wake all restart the watchdog and its prescaler
    if (core_evt.watchdog_clear_instr || core_evt.sleep_instr || next_s.ctl.wake_pulse) begin
      next_s.wdt = 22'h00_0000;
      next_s.pre = 7'h00;
    end
  end

  // Single state register; reset loads constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.phase <= isw_pkg::Q1;
      s.interrupt_control <= isw_pkg::INT_CTL_RST;
      s.peripheral_interrupt_flags <= isw_pkg::PER_FLAGS_RST;
      s.option_control <= isw_pkg::OPTION_RST;
      s.peripheral_interrupt_enables <= isw_pkg::PER_ENABLES_RST;
      s.timeout_status <= 1'b1;
      s.powerdown_status <= 1'b1;
      s.ctl.osc_enable <= 1'b1;
      s.ctl.vector_addr <= isw_pkg::IRQ_VECTOR;
    end else begin
      s <= next_s;
    end
  end

  // Checks on the design's own outputs and state
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  phase_wrap_a: assert property (s.phase == isw_pkg::Q4 |=> s.phase == isw_pkg::Q1)
    else $error("phase did not wrap to the first phase");
  vector_gie_a: assert property (s.ctl.irq_vector_take |-> !s.interrupt_control[isw_pkg::B_GIE]
    && s.ctl.vector_addr == 13'h0004)
    else $error("vector taken with global enable still set");
  vector_phase_a: assert property (s.ctl.irq_vector_take |-> s.phase == isw_pkg::Q2)
    else $error("vector not issued right after a first phase");
  // An enable clear anywhere in the countdown legally drops the take, so only uncancelled runs are timed
  take_latency_a: assert property ($rose(s.take_cnt != 2'h0) && !core_evt.gie_clear_instr
    ##1 (!core_evt.gie_clear_instr) [*7] |-> ##[0:2] s.ctl.irq_vector_take)
    else $error("vector latency out of range");
  take_gate_a: assert property ($rose(s.take_cnt != 2'h0) |-> $past(s.interrupt_control[isw_pkg::B_GIE])
    && $past(s.phase) == isw_pkg::Q1)
    else $error("recognition outside a first phase or without global enable");
  sleep_hold_a: assert property (s.ctl.sleeping && s.take_cnt == 2'h0 |=> s.take_cnt == 2'h0)
    else $error("recognition started while asleep");
  port_flag_a: assert property (port_chg |=> s.interrupt_control[isw_pkg::B_PCIF])
    else $error("port change did not set its flag");
  cmp_flag_a: assert property (core_evt.comparator_event |=> s.peripheral_interrupt_flags[isw_pkg::B_CMP])
    else $error("comparator event did not set its flag");
  gie_clear_a: assert property (core_evt.gie_clear_instr |=> !s.interrupt_control[isw_pkg::B_GIE])
    else $error("enable clear instruction left global enable set");
  nop_pulse_a: assert property (s.ctl.nop_cycle |=> !s.ctl.nop_cycle)
    else $error("no-op pulse longer than one cycle");
  edge_fall_a: assert property (ext_edge && !s.option_control[isw_pkg::B_EDGE] |-> !s.ext_s2)
    else $error("rising edge taken while falling edge selected");
  sleep_osc_a: assert property (s.ctl.sleeping |-> !s.ctl.osc_enable)
    else $error("oscillator running during power-down");
  wdt_wake_a: assert property (s.ctl.sleeping && wdt_timeout |=> s.ctl.wake_pulse
    && !s.ctl.watchdog_reset && !s.timeout_status)
    else $error("watchdog time-out in sleep did not wake cleanly");
  wake_clear_a: assert property (s.ctl.wake_pulse |-> s.wdt == 22'h00_0000 && s.pre == 7'h00)
    else $error("wake-up left the watchdog running on");
  cfg_ro_a: assert property (wr_fire && apb_req.paddr == isw_pkg::ADDR_CONFIG |=> s.cfg == $past(s.cfg))
    else $error("configuration strap changed by a write");
  ready_pulse_a: assert property (s.rsp.pready |=> !s.rsp.pready)
    else $error("ready held longer than one cycle");
  return_gie_a: assert property (core_evt.return_from_irq && !core_evt.gie_clear_instr && !wr_fire
    |=> s.interrupt_control[isw_pkg::B_GIE])
    else $error("return did not set global enable");
  nop_cancel_a: assert property (core_evt.gie_clear_instr |=> s.take_cnt == 2'h0
    && !s.ctl.irq_vector_take ##1 !s.ctl.irq_vector_take)
    else $error("take not cancelled after enable clear");
  timer_flag_a: assert property (core_evt.timer_overflow |=> s.interrupt_control[isw_pkg::B_TIMER_OVERFLOW_FLAG])
    else $error("timer flag missed its event");
  ext_flag_a: assert property (ext_edge |=> s.interrupt_control[isw_pkg::B_EXTIF])
    else $error("pin edge did not set its flag");
  sleep_entry_a: assert property (core_evt.sleep_instr |=> !s.powerdown_status && s.wdt == 22'h00_0000)
    else $error("sleep entry status wrong");
  wdt_clear_a: assert property (core_evt.watchdog_clear_instr |=> s.wdt == 22'h00_0000
    && s.pre == 7'h00)
    else $error("watchdog not cleared");
  wdt_reset_a: assert property (s.ctl.watchdog_reset |-> !s.timeout_status
    && !$past(s.ctl.sleeping))
    else $error("watchdog reset with wrong status");
  wake_a: assert property (s.ctl.sleeping && any_enabled |=> !s.ctl.sleeping
    && s.ctl.wake_pulse && s.ctl.osc_enable)
    else $error("enabled source failed to wake");
  wdt_off_a: assert property (s.cfg_loaded && !s.cfg[isw_pkg::B_WATCHDOG_ENABLE_CFG] |-> !wdt_timeout)
    else $error("disabled watchdog timed out");

  take_seen_c: cover property (s.ctl.irq_vector_take);
  wake_seen_c: cover property (s.ctl.wake_pulse ##[1:12] s.ctl.irq_vector_take);
  wdt_reset_c: cover property (s.ctl.watchdog_reset);
  nop_seen_c: cover property (s.ctl.nop_cycle);
  wdt_wake_c: cover property (s.ctl.sleeping && wdt_timeout);

endmodule

/* core/isw_pkg.sv */
// Purpose: Shared constants, types and carriers for the interrupt, sleep and watchdog control block.
// Assumes: One 200 MHz clock; registers reached over APB with 32-bit data and word-aligned addresses.
// Notes: Register indices are multiplied by four to form byte addresses.
package isw_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WDT_TIMEOUT_US = 18000;
  localparam int WDT_CYCLES = (WDT_TIMEOUT_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam logic [1:0] TAKE_LATENCY = 2'h2;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // Register indices and byte addresses
  localparam logic [15:0] IDX_INT_CTL = 16'h000b;
  localparam logic [15:0] IDX_PER_FLAGS = 16'h000c;
  localparam logic [15:0] IDX_OPTION = 16'h0081;
  localparam logic [15:0] IDX_PER_ENABLES = 16'h008c;
  localparam logic [15:0] IDX_CORE_STATUS = 16'h0083;
  localparam logic [15:0] IDX_CONFIG = 16'h2007;
  localparam logic [15:0] ADDR_INT_CTL = {IDX_INT_CTL[13:0], 2'h0};
  localparam logic [15:0] ADDR_PER_FLAGS = {IDX_PER_FLAGS[13:0], 2'h0};
  localparam logic [15:0] ADDR_OPTION = {IDX_OPTION[13:0], 2'h0};
  localparam logic [15:0] ADDR_PER_ENABLES = {IDX_PER_ENABLES[13:0], 2'h0};
  localparam logic [15:0] ADDR_CORE_STATUS = {IDX_CORE_STATUS[13:0], 2'h0};
  localparam logic [15:0] ADDR_CONFIG = {IDX_CONFIG[13:0], 2'h0};

  // Field positions
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int B_TIMER_OVERFLOW_ENABLE = 5;
  localparam int B_EXTIE = 4;
  localparam int B_PCIE = 3;
  localparam int B_TIMER_OVERFLOW_FLAG = 2;
  localparam int B_EXTIF = 1;
  localparam int B_PCIF = 0;
  localparam int B_CMP = 6;
  localparam int B_EDGE = 6;
  localparam int B_PSA = 3;
  localparam int B_PS = 0;
  localparam int B_WATCHDOG_ENABLE_CFG = 2;
  localparam int B_TO = 4;
  localparam int B_PD = 3;

  // Reset values
  localparam logic [7:0] INT_CTL_RST = 8'h00;
  localparam logic [7:0] PER_FLAGS_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] PER_ENABLES_RST = 8'h00;

  typedef enum logic [1:0] {
    Q1 = 2'h0,
    Q2 = 2'h1,
    Q3 = 2'h2,
    Q4 = 2'h3
  } isw_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } isw_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } isw_apb_rsp_t;

  typedef struct packed {
    logic return_from_irq;
    logic gie_clear_instr;
    logic watchdog_clear_instr;
    logic sleep_instr;
    logic port_read;
    logic timer_overflow;
    logic comparator_event;
  } isw_core_evt_t;

  typedef struct packed {
    isw_phase_t phase;
    logic irq_vector_take;
    logic [12:0] vector_addr;
    logic nop_cycle;
    logic sleeping;
    logic osc_enable;
    logic watchdog_reset;
    logic wake_pulse;
  } isw_core_ctl_t;

endpackage

/* sim/isw_core_model.sv */
// Purpose: Core-side partner that issues instruction events and counts control pulses.
// Assumes: Bench commands are one-cycle pulses launched just after a rising edge.
// Notes: Events leave one cycle after the command, like a registered decode stage.
`timescale 1ns/1ps
module isw_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire isw_pkg::isw_core_ctl_t core_ctl,
  input wire isw_pkg::isw_core_evt_t cmd,
  output isw_pkg::isw_core_evt_t core_evt,
  output int take_cnt,
  output int nop_cnt,
  output int wake_cnt,
  output int wdr_cnt
);
  // Registered decode keeps events clear of the bench's own edge; counters see each pulse once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_evt <= '0;
      take_cnt <= 0;
      nop_cnt <= 0;
      wake_cnt <= 0;
      wdr_cnt <= 0;
    end else begin
      core_evt <= cmd;
      take_cnt <= take_cnt + int'(core_ctl.irq_vector_take);
      nop_cnt <= nop_cnt + int'(core_ctl.nop_cycle);
      wake_cnt <= wake_cnt + int'(core_ctl.wake_pulse);
      wdr_cnt <= wdr_cnt + int'(core_ctl.watchdog_reset);
    end
  end
endmodule

/* sim/test_isw_ctrl.sv */
// Purpose: Self-checking bench for the interrupt, sleep and watchdog block.
// Assumes: Watchdog count shortened to 40 clocks so time-outs fit a short run.
// Notes: APB answers are taken at the rising edge that samples pready; other outputs at the falling edge.
`timescale 1ns/1ps
module test_isw_ctrl;
  localparam logic [15:0] IC = isw_pkg::ADDR_INT_CTL;
  localparam logic [15:0] PF = isw_pkg::ADDR_PER_FLAGS;
  localparam logic [15:0] OP = isw_pkg::ADDR_OPTION;
  localparam logic [15:0] PE = isw_pkg::ADDR_PER_ENABLES;
  localparam logic [15:0] ST = isw_pkg::ADDR_CORE_STATUS;
  localparam logic [15:0] CF = isw_pkg::ADDR_CONFIG;
  localparam int RET = 6, GCL = 5, WCL = 4, SLP = 3, PRD = 2, TMR = 1, CMP = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  isw_pkg::isw_apb_req_t req = '0;
  isw_pkg::isw_apb_rsp_t rsp;
  isw_pkg::isw_core_evt_t cmd = '0;
  isw_pkg::isw_core_evt_t evt;
  isw_pkg::isw_core_ctl_t ctl;
  logic ext_irq_pin = 1'b0;
  logic [3:0] port_b_pins = 4'h0;
  logic [7:0] cfg = 8'h04;
  int take_cnt, nop_cnt, wake_cnt, wdr_cnt;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, t0;

  isw_ctrl #(.WDT_CYCLES(40)) u_isw_ctrl (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .core_evt(evt), .core_ctl(ctl), .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins),
    .configuration_word(cfg));
  isw_core_model u_isw_core_model (.clk(clk), .rst(rst), .core_ctl(ctl), .cmd(cmd), .core_evt(evt),
    .take_cnt(take_cnt), .nop_cnt(nop_cnt), .wake_cnt(wake_cnt), .wdr_cnt(wdr_cnt));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Hang guard: the whole sequence needs under a thousand clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask

  // APB transfer: request held until the edge that samples pready, answer taken there
  task automatic acc(input string nm, input logic wr, input logic [15:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic exp_err);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    if (!wr) chk(nm, exp, rsp.prdata);
    chk({nm, " err"}, 32'(exp_err), 32'(rsp.pslverr));
    req <= '0;
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    cmd <= isw_pkg::isw_core_evt_t'(7'h01 << k);
    @(posedge clk);
    cmd <= '0;
  endtask

  // Pin edge, then room for the two-flop synchroniser and the flag
  task automatic pin(input logic v);
    @(posedge clk);
    ext_irq_pin <= v;
    wt(8);
  endtask

  initial begin
    wt(2);
    rst <= 1'b0;
    // Reset values, read-only and unmapped places
    acc("ic", 0, IC, '0, 32'h0000_0000, 0);
    acc("opt", 0, OP, '0, 32'h0000_00ff, 0);
    acc("pf", 0, PF, '0, 32'h0000_0000, 0);
    acc("pe", 0, PE, '0, 32'h0000_0000, 0);
    acc("st", 0, ST, '0, 32'h0000_0018, 0);
    acc("cfg", 0, CF, '0, 32'h0000_0004, 0);
    acc("cfg wr", 1, CF, 32'h0000_00ff, '0, 1);
    acc("hole", 0, 16'h0100, '0, 32'h0000_0000, 1);
    acc("pe", 1, PE, 32'h0000_00ff, '0, 0);
    acc("pe", 0, PE, '0, 32'h0000_0040, 0);
    $display("test registers done");
    // Every source flags itself with all interrupt control enables clear
    pulse(TMR);
    pulse(CMP);
    pin(1'b1);
    @(posedge clk) port_b_pins <= 4'ha;
    wt(8);
    acc("ic flags", 0, IC, '0, 32'h0000_0007, 0);
    acc("pf", 0, PF, '0, 32'h0000_0040, 0);
    chk("no take", 0, take_cnt);
    pulse(PRD);
    acc("clr", 1, IC, '0, '0, 0);
    acc("clr", 1, PF, '0, '0, 0);
    acc("opt", 1, OP, 32'h0000_00bf, '0, 0);
    pin(1'b0);
    acc("fall", 0, IC, '0, 32'h0000_0002, 0);
    acc("clr", 1, IC, '0, '0, 0);
    pin(1'b1);
    acc("rise", 0, IC, '0, 32'h0000_0000, 0);
    $display("test flags done");
    // Take, latency, cancel by enable clear, return re-enables
    acc("en", 1, IC, 32'h0000_00a0, '0, 0);
    pulse(TMR);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ctl.irq_vector_take !== 1'b1 && n < 40);
    chk("latency", 1, 32'(n >= 11 && n <= 14));
    chk("vector", 32'h0000_0004, 32'(ctl.vector_addr));
    chk("phase", 32'(isw_pkg::Q2), 32'(ctl.phase));
    acc("gie off", 0, IC, '0, 32'h0000_0024, 0);
    t0 = take_cnt;
    acc("gie on", 1, IC, 32'h0000_00a4, '0, 0);
    pulse(GCL);
    wt(20);
    chk("nop", 1, nop_cnt);
    chk("no take", t0, take_cnt);
    acc("held", 0, IC, '0, 32'h0000_0024, 0);
    pulse(RET);
    wt(20);
    chk("retake", t0 + 1, take_cnt);
    acc("gie only", 1, IC, 32'h0000_0080, '0, 0);
    t0 = take_cnt;
    pin(1'b0);
    wt(12);
    chk("pin masked", t0, take_cnt);
    acc("pin flag", 0, IC, '0, 32'h0000_0082, 0);
    acc("clr", 1, IC, '0, '0, 0);
    $display("test interrupts done");
    // Watchdog while awake: clears hold it off, then it times out
    acc("opt", 1, OP, 32'h0000_0040, '0, 0);
    t0 = wdr_cnt;
    repeat (6) begin
      pulse(WCL);
      wt(20);
    end
    chk("wdt held", t0, wdr_cnt);
    wt(40);
    chk("wdt fired", t0 + 1, wdr_cnt);
    acc("to", 0, ST, '0, 32'h0000_0008, 0);
    acc("opt", 1, OP, 32'h0000_00ff, '0, 0);
    $display("test watchdog done");
    // Sleep and wake by an enabled source, with and without global enable
    for (int g = 0; g < 2; g++) begin
      acc("en", 1, IC, g ? 32'h0000_00a0 : 32'h0000_0020, '0, 0);
      t0 = take_cnt;
      pulse(SLP);
      wt(2);
      @(negedge clk);
      chk("sleeping", 1, 32'(ctl.sleeping));
      chk("osc off", 0, 32'(ctl.osc_enable));
      acc("pd", 0, ST, '0, 32'h0000_0010, 0);
      pulse(TMR);
      wt(4);
      @(negedge clk);
      chk("awake", 0, 32'(ctl.sleeping));
      wt(20);
      chk("vector", t0 + g, take_cnt);
      chk("wake", g + 1, wake_cnt);
    end
    // Comparator wakes through the peripheral enable path
    acc("en", 1, IC, 32'h0000_0040, '0, 0);
    pulse(SLP);
    wt(4);
    pulse(CMP);
    wt(4);
    chk("cmp wake", 3, wake_cnt);
    // Watchdog time-out in sleep wakes instead of resetting
    acc("clr", 1, IC, '0, '0, 0);
    acc("clr", 1, PF, '0, '0, 0);
    acc("opt", 1, OP, 32'h0000_0040, '0, 0);
    t0 = wdr_cnt;
    pulse(SLP);
    wt(50);
    chk("wdt wake", 4, wake_cnt);
    chk("no reset", t0, wdr_cnt);
    acc("to pd", 0, ST, '0, 32'h0000_0000, 0);
    $display("test sleep done");
    // Strap with watchdog enable clear keeps it silent
    @(posedge clk) cfg <= 8'h00;
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    acc("opt", 1, OP, 32'h0000_0040, '0, 0);
    wt(100);
    chk("wdt off", 0, wdr_cnt);
    $display("test strap done");
    final_report();
  end
endmodule
